// ===== dmi_dev.sv
// Demodulator end: two-wire register slave and input sample conditioning
//
// The two-wire serial port was chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none

module dmi_dev
    import dmi_pkg::*;
#(
    parameter int          SAMPLE_W   = 6,
    parameter logic [7:0]  RELEASE_ID = DMI_RELEASE_ID
)(
    input  wire logic                i_clk_sys,    // System clock
    input  wire logic                i_nrst,       // Synchronous reset, active low
    dmi_if.dev                       bus,          // Two-wire bus
    input  wire logic [SAMPLE_W-1:0] i_i_sample,   // In-phase sample
    input  wire logic [SAMPLE_W-1:0] i_q_sample,   // Quadrature sample
    input  wire logic [SAMPLE_W:0]   i_flt_i,      // Filtered in-phase return
    input  wire logic [SAMPLE_W:0]   i_flt_q,      // Filtered quadrature return
    output logic      [SAMPLE_W:0]   o_flt_in_i,   // Conditioned in-phase to filter
    output logic      [SAMPLE_W:0]   o_flt_in_q,   // Conditioned quadrature to filter
    output logic      [SAMPLE_W:0]   o_rec_i,      // In-phase to recovery
    output logic      [SAMPLE_W:0]   o_rec_q,      // Quadrature to recovery
    output logic                     o_nyq_en,     // Nyquist filter enabled
    output logic                     o_bpsk,       // BPSK selected
    output logic      [7:0]          o_cfg         // Configuration register image
);

    generate
        if (SAMPLE_W < 2)
        begin : g_chk
            $error("SAMPLE_W must be at least 2");
        end
    endgenerate

    typedef enum {ST_IDLE, ST_RX, ST_RX_ACK, ST_TX, ST_TX_ACK} dmi_dstate_t;
    typedef enum {K_ADDR, K_INDEX, K_DATA} dmi_kind_t;

    dmi_dstate_t state;
    dmi_kind_t   kind;
    logic        scl_m, scl_s, scl_d;
    logic        sda_m, sda_s, sda_d;
    logic [3:0]  bitcnt;
    logic [7:0]  shreg, tx, ptr, rd_byte;
    logic        is_rd, mack, oe;
    logic [3:0]  cfg;
    logic        scl_rise, scl_fall, bus_start, bus_stop;
    logic        byte_done, tx_load;

    function automatic logic [7:0] reg_read(input logic [7:0] idx, input logic [3:0] c);
        if (idx == DMI_IDX_CFG)
            reg_read = {4'h0, c};
        else if (idx == DMI_IDX_ID)
            reg_read = RELEASE_ID;
        else
            reg_read = 8'h00;
    endfunction : reg_read

    function automatic logic [SAMPLE_W:0] to_signed(input logic [SAMPLE_W-1:0] s, input logic sgn);
        logic [SAMPLE_W-1:0] v;
        v = sgn ? s : {~s[SAMPLE_W-1], s[SAMPLE_W-2:0]};
        to_signed = {v[SAMPLE_W-1], v};
    endfunction : to_signed

    // Bus lines come from another clock domain
    always_ff @(posedge i_clk_sys)
    begin
        if (!i_nrst)
        begin
            scl_m <= 1'b1;
            scl_s <= 1'b1;
            scl_d <= 1'b1;
            sda_m <= 1'b1;
            sda_s <= 1'b1;
            sda_d <= 1'b1;
        end
        else
        begin
            scl_m <= bus.scl;
            scl_s <= scl_m;
            scl_d <= scl_s;
            sda_m <= bus.sda;
            sda_s <= sda_m;
            sda_d <= sda_s;
        end
    end

    assign scl_rise  = scl_s & ~scl_d;
    assign scl_fall  = ~scl_s & scl_d;
    assign bus_start = scl_s & scl_d & sda_d & ~sda_s;
    assign bus_stop  = scl_s & scl_d & ~sda_d & sda_s;
    assign rd_byte   = reg_read(ptr, cfg);
    assign byte_done = (state == ST_RX) && scl_fall && (bitcnt == 4'h8);
    assign tx_load   = scl_fall && (((state == ST_RX_ACK) && (kind == K_ADDR) && is_rd) ||
                                    ((state == ST_TX_ACK) && mack));

    // Byte level protocol engine
    always_ff @(posedge i_clk_sys)
    begin
        if (!i_nrst)
        begin
            state  <= ST_IDLE;
            kind   <= K_ADDR;
            bitcnt <= 4'h0;
            shreg  <= 8'h00;
            tx     <= 8'h00;
            is_rd  <= 1'b0;
            mack   <= 1'b0;
            oe     <= 1'b0;
        end
        else if (bus_start)
        begin
            // Repeated start also lands here
            state  <= ST_RX;
            kind   <= K_ADDR;
            bitcnt <= 4'h0;
            oe     <= 1'b0;
        end
        else if (bus_stop)
        begin
            state <= ST_IDLE;
            oe    <= 1'b0;
        end
        else if (tx_load)
        begin
            tx     <= rd_byte;
            oe     <= ~rd_byte[7];
            bitcnt <= 4'h0;
            state  <= ST_TX;
        end
        else
        begin
            case (state)
                ST_IDLE:
                begin
                    oe <= 1'b0;
                end
                ST_RX:
                begin
                    if (scl_rise)
                    begin
                        shreg  <= {shreg[6:0], sda_s};
                        bitcnt <= bitcnt + 4'h1;
                    end
                    else if (byte_done)
                    begin
                        if (kind != K_ADDR || shreg[7:1] == DMI_SLAVE_ADDR)
                        begin
                            oe    <= 1'b1;
                            state <= ST_RX_ACK;
                            if (kind == K_ADDR)
                                is_rd <= shreg[0];
                        end
                        else
                            state <= ST_IDLE;
                    end
                end
                ST_RX_ACK:
                begin
                    if (scl_fall)
                    begin
                        oe     <= 1'b0;
                        bitcnt <= 4'h0;
                        state  <= ST_RX;
                        kind   <= (kind == K_ADDR) ? K_INDEX : K_DATA;
                    end
                end
                ST_TX:
                begin
                    if (scl_rise)
                        bitcnt <= bitcnt + 4'h1;
                    else if (scl_fall)
                    begin
                        if (bitcnt == 4'h8)
                        begin
                            oe    <= 1'b0;
                            state <= ST_TX_ACK;
                        end
                        else
                        begin
                            tx <= {tx[6:0], 1'b0};
                            oe <= ~tx[6];
                        end
                    end
                end
                ST_TX_ACK:
                begin
                    if (scl_rise)
                        mack <= ~sda_s;
                    else if (scl_fall)
                        state <= ST_IDLE;
                end
                default:
                begin
                    state <= ST_IDLE;
                end
            endcase
        end
    end

    // Pointer is untouched by stop, so a read resumes where the index left it
    always_ff @(posedge i_clk_sys)
    begin
        if (!i_nrst)
            ptr <= 8'h00;
        else if (byte_done && kind == K_INDEX)
            ptr <= shreg;
        else if ((byte_done && kind == K_DATA) || tx_load)
            ptr <= ptr + 8'h01;
    end

    // Only the configuration register is writable; upper bits are not stored
    always_ff @(posedge i_clk_sys)
    begin
        if (!i_nrst)
            cfg <= DMI_CFG_RESET;
        else if (byte_done && kind == K_DATA && ptr == DMI_IDX_CFG)
            cfg <= shreg[3:0];
    end

    // Sample conditioning ahead of the filter and recovery loops
    always_ff @(posedge i_clk_sys)
    begin
        if (!i_nrst)
        begin
            o_flt_in_i <= '0;
            o_flt_in_q <= '0;
            o_rec_i    <= '0;
            o_rec_q    <= '0;
        end
        else
        begin
            o_flt_in_i <= to_signed(i_i_sample, cfg[DMI_CFG_SIGNED]);
            if (cfg[DMI_CFG_QNEG])
                o_flt_in_q <= -to_signed(i_q_sample, cfg[DMI_CFG_SIGNED]);
            else
                o_flt_in_q <= to_signed(i_q_sample, cfg[DMI_CFG_SIGNED]);
            if (cfg[DMI_CFG_NYQ])
            begin
                o_rec_i <= i_flt_i;
                o_rec_q <= i_flt_q;
            end
            else
            begin
                o_rec_i <= o_flt_in_i;
                o_rec_q <= o_flt_in_q;
            end
        end
    end

    assign o_nyq_en       = cfg[DMI_CFG_NYQ];
    assign o_bpsk         = cfg[DMI_CFG_BPSK];
    assign o_cfg          = {4'h0, cfg};
    assign bus.sda_dev_o  = 1'b0;
    assign bus.sda_dev_oe = oe;

endmodule : dmi_dev
`default_nettype wire

// ===== dmi_pkg.sv
// Shared constants and types of the demodulator two-wire register port
package dmi_pkg;

    // Bus addressing
    localparam logic [6:0] DMI_SLAVE_ADDR  = 7'h68;
    localparam logic [7:0] DMI_ADDR_WRITE  = 8'hd0;
    localparam logic [7:0] DMI_ADDR_READ   = 8'hd1;

    // Device register indices
    localparam logic [7:0] DMI_IDX_CFG     = 8'h00;
    localparam logic [7:0] DMI_IDX_ID      = 8'h0b;

    // Input configuration fields and reset value
    localparam int         DMI_CFG_QNEG    = 0;
    localparam int         DMI_CFG_SIGNED  = 1;
    localparam int         DMI_CFG_NYQ     = 2;
    localparam int         DMI_CFG_BPSK    = 3;
    localparam logic [3:0] DMI_CFG_RESET   = 4'h4;

    // Release code; this value is arbitrary
    localparam logic [7:0] DMI_RELEASE_ID  = 8'h5a;

    // Host command registers
    localparam logic [2:0] DMI_HREG_INDEX  = 3'h0;
    localparam logic [2:0] DMI_HREG_WDATA  = 3'h1;
    localparam logic [2:0] DMI_HREG_CTRL   = 3'h2;
    localparam logic [2:0] DMI_HREG_STATUS = 3'h3;
    localparam logic [2:0] DMI_HREG_RDATA  = 3'h4;
    localparam int         DMI_CTRL_GO_WR  = 0;
    localparam int         DMI_CTRL_GO_RD  = 1;
    localparam int         DMI_STAT_BUSY   = 0;
    localparam int         DMI_STAT_NACK   = 1;

    // Serial clock timing made by the host
    localparam int         DMI_CLK_NS      = 50;
    localparam int         DMI_SCL_NS      = 10000;
    localparam int         DMI_QTR_CYC     = (DMI_SCL_NS / 4 + DMI_CLK_NS - 1) / DMI_CLK_NS;

    typedef enum logic [2:0] {DMI_ACT_START, DMI_ACT_TX, DMI_ACT_RX, DMI_ACT_STOP, DMI_ACT_END} dmi_act_t;

endpackage : dmi_pkg

// ===== dmi_if.sv
// Two-wire bus between host master and demodulator register port
`timescale 1ns/1ps
`default_nettype none
interface dmi_if;
    logic scl;          // Serial clock, driven by host only
    logic sda_host_o;   // Host data out value
    logic sda_host_oe;  // Host drives data line
    logic sda_dev_o;    // Device data out value
    logic sda_dev_oe;   // Device drives data line
    logic sda;          // Resolved line level, pulled up

    // Open drain: any enabled driver at zero pulls the line low
    assign sda = ~((sda_host_oe & ~sda_host_o) | (sda_dev_oe & ~sda_dev_o));

    modport dev  (input scl, input sda, output sda_dev_o, output sda_dev_oe);
    modport host (output scl, input sda, output sda_host_o, output sda_host_oe);
endinterface : dmi_if
`default_nettype wire

// ===== dmi_host.sv
// Host end: two-wire master driven by a small command register set
`timescale 1ns/1ps
`default_nettype none
module dmi_host
    import dmi_pkg::*;
#(
    parameter int QTR_CYC = DMI_QTR_CYC
)(
    input  wire logic       i_clk_sys,   // System clock
    input  wire logic       i_nrst,      // Synchronous reset, active low
    dmi_if.host             bus,         // Two-wire bus
    input  wire logic [2:0] i_addr,      // Command register address
    input  wire logic [7:0] i_wdata,     // Write data
    input  wire logic       i_wr,        // Write strobe
    input  wire logic       i_rd,        // Read strobe
    output logic      [7:0] o_rdata      // Read data, cycle after strobe
);

    // Quarter bit must outlast both synchroniser delays
    generate
        if (QTR_CYC < 8 || QTR_CYC > 65536)
        begin : g_chk
            $error("QTR_CYC must be 8 to 65536");
        end
    endgenerate

    logic [15:0] div;
    logic        tick;
    logic        busy, is_read, nack;
    logic [3:0]  step, bitn;
    logic [1:0]  phase;
    logic [7:0]  index, wdata, rxd;
    logic        scl, sda_rel;
    logic        sda_m, sda_s;
    dmi_act_t    act;
    logic [7:0]  txb;
    logic        go;

    function automatic dmi_act_t step_act(input logic rd, input logic [3:0] s);
        if (s == 4'h0 || (rd && s == 4'h4))
            step_act = DMI_ACT_START;
        else if ((!rd && s == 4'h4) || (rd && (s == 4'h3 || s == 4'h7)))
            step_act = DMI_ACT_STOP;
        else if (rd && s == 4'h6)
            step_act = DMI_ACT_RX;
        else if ((!rd && s > 4'h4) || (rd && s > 4'h7))
            step_act = DMI_ACT_END;
        else
            step_act = DMI_ACT_TX;
    endfunction : step_act

    function automatic logic [7:0] step_byte(input logic rd, input logic [3:0] s,
                                             input logic [7:0] idx, input logic [7:0] wd);
        if (s == 4'd1)
            step_byte = DMI_ADDR_WRITE;
        else if (s == 4'd2)
            step_byte = idx;
        else if (rd)
            step_byte = DMI_ADDR_READ;
        else
            step_byte = wd;
    endfunction : step_byte

    assign act  = step_act(is_read, step);
    assign txb  = step_byte(is_read, step, index, wdata);
    assign tick = (div == 16'(QTR_CYC - 1));
    assign go   = i_wr && (i_addr == DMI_HREG_CTRL) && !busy;

    always_ff @(posedge i_clk_sys)
    begin
        if (!i_nrst || !busy || tick)
            div <= 16'h0000;
        else
            div <= div + 16'h0001;
    end

    always_ff @(posedge i_clk_sys)
    begin
        if (!i_nrst)
        begin
            sda_m <= 1'b1;
            sda_s <= 1'b1;
        end
        else
        begin
            sda_m <= bus.sda;
            sda_s <= sda_m;
        end
    end

    // Command registers; software keeps unused device bits at zero
    always_ff @(posedge i_clk_sys)
    begin
        if (!i_nrst)
        begin
            index <= 8'h00;
            wdata <= 8'h00;
        end
        else if (i_wr && i_addr == DMI_HREG_INDEX)
            index <= i_wdata;
        else if (i_wr && i_addr == DMI_HREG_WDATA)
            wdata <= i_wdata;
    end

    always_ff @(posedge i_clk_sys)
    begin
        if (!i_nrst)
            o_rdata <= 8'h00;
        else if (i_rd)
        begin
            if (i_addr == DMI_HREG_INDEX)
                o_rdata <= index;
            else if (i_addr == DMI_HREG_WDATA)
                o_rdata <= wdata;
            else if (i_addr == DMI_HREG_STATUS)
                o_rdata <= {6'h00, nack, busy};
            else if (i_addr == DMI_HREG_RDATA)
                o_rdata <= rxd;
            else
                o_rdata <= 8'h00;
        end
    end

    // Bit sequencer: four quarter phases per bit, start or stop
    always_ff @(posedge i_clk_sys)
    begin
        if (!i_nrst)
        begin
            busy    <= 1'b0;
            is_read <= 1'b0;
            nack    <= 1'b0;
            step    <= 4'h0;
            bitn    <= 4'h0;
            phase   <= 2'h0;
            rxd     <= 8'h00;
            scl     <= 1'b1;
            sda_rel <= 1'b1;
        end
        else if (go && (i_wdata[DMI_CTRL_GO_WR] || i_wdata[DMI_CTRL_GO_RD]))
        begin
            busy    <= 1'b1;
            is_read <= i_wdata[DMI_CTRL_GO_RD];
            nack    <= 1'b0;
            step    <= 4'h0;
            bitn    <= 4'h0;
            phase   <= 2'h0;
        end
        else if (busy && tick)
        begin
            phase <= phase + 2'h1;
            case (act)
                DMI_ACT_START:
                begin
                    if (phase == 2'd0)
                        sda_rel <= 1'b1;
                    else if (phase == 2'd1)
                        scl <= 1'b1;
                    else if (phase == 2'd2)
                        sda_rel <= 1'b0;
                    else
                    begin
                        scl  <= 1'b0;
                        step <= step + 4'h1;
                    end
                end
                DMI_ACT_STOP:
                begin
                    if (phase == 2'd0)
                        sda_rel <= 1'b0;
                    else if (phase == 2'd1)
                        scl <= 1'b1;
                    else if (phase == 2'd2)
                        sda_rel <= 1'b1;
                    else
                        step <= step + 4'h1;
                end
                DMI_ACT_TX, DMI_ACT_RX:
                begin
                    if (phase == 2'd0)
                        sda_rel <= (act == DMI_ACT_RX) || (bitn == 4'd8) || txb[3'(4'd7 - bitn)];
                    else if (phase == 2'd1)
                        scl <= 1'b1;
                    else if (phase == 2'd2)
                    begin
                        if (act == DMI_ACT_TX && bitn == 4'd8 && sda_s)
                            nack <= 1'b1;
                        else if (act == DMI_ACT_RX && bitn != 4'd8)
                            rxd <= {rxd[6:0], sda_s};
                    end
                    else
                    begin
                        scl <= 1'b0;
                        if (bitn == 4'd8)
                        begin
                            bitn <= 4'h0;
                            step <= step + 4'h1;
                        end
                        else
                            bitn <= bitn + 4'h1;
                    end
                end
                default:
                begin
                    busy  <= 1'b0;
                    phase <= 2'h0;
                end
            endcase
        end
    end

    assign bus.scl         = scl;
    assign bus.sda_host_o  = 1'b0;
    assign bus.sda_host_oe = ~sda_rel;

endmodule : dmi_host
`default_nettype wire

// ===== dmi_assertions.sv
// Checker of the two-wire link between the host and device ends
`timescale 1ns/1ps
`default_nettype none
module dmi_assertions (
    input wire logic i_clk_sys,     // System clock
    input wire logic i_nrst,        // Sync reset, active low
    input wire logic i_scl,         // Serial clock
    input wire logic i_sda,         // Resolved data line
    input wire logic i_sda_host_oe, // Host pulls data low
    input wire logic i_sda_dev_oe   // Device pulls data low
);
    default clocking cb @(posedge i_clk_sys);
    endclocking
    default disable iff (!i_nrst);

    // Reset checks must run while reset is low
    property p_dev_rst;
        disable iff (1'b0) !i_nrst |=> !i_sda_dev_oe;
    endproperty
    a_dev_rst: assert property (p_dev_rst) else $error("device drives data in reset");
    property p_host_rst;
        disable iff (1'b0) !i_nrst |=> i_scl && !i_sda_host_oe;
    endproperty
    a_host_rst: assert property (p_host_rst) else $error("host not idle in reset");
    property p_dev_stable;
        i_scl && $past(i_scl) |-> $stable(i_sda_dev_oe);
    endproperty
    a_dev_stable: assert property (p_dev_stable) else $error("device data moved with clock high");
    property p_ack_low;
        $rose(i_sda_dev_oe) |-> !i_scl [*8];
    endproperty
    a_ack_low: assert property (p_ack_low) else $error("device pull outside clock low");
    property p_dev_release;
        $rose(i_sda_dev_oe) |-> ##[1:300] !i_sda_dev_oe;
    endproperty
    a_dev_release: assert property (p_dev_release) else $error("device holds data line");
    property p_start_host;
        $fell(i_sda) && i_scl |-> i_sda_host_oe && !i_sda_dev_oe;
    endproperty
    a_start_host: assert property (p_start_host) else $error("start not made by host");
    property p_stop_idle;
        $rose(i_sda) && i_scl && $past(i_scl) |-> i_scl [*8];
    endproperty
    a_stop_idle: assert property (p_stop_idle) else $error("clock low right after stop");
    property p_scl_high;
        $rose(i_scl) |-> i_scl [*8];
    endproperty
    a_scl_high: assert property (p_scl_high) else $error("clock high too short");
    c_ack: cover property ($rose(i_sda_dev_oe));
    c_start: cover property ($fell(i_sda) && i_scl);
    c_stop: cover property ($rose(i_sda) && i_scl);
endmodule : dmi_assertions
`default_nettype wire

// ===== tb.sv
// Self-checking bench joining host and device ends over the link
`timescale 1ns/1ps
`default_nettype none
module tb;
    import dmi_pkg::*;
    logic       i_clk_sys, i_nrst, i_wr, i_rd;
    logic [2:0] i_addr;
    logic [7:0] i_wdata, o_rdata, d, cfg;
    logic [5:0] smp_i, smp_q;
    logic [6:0] flt_i, flt_q, fin_i, fin_q, rec_i, rec_q, ei, eq;
    logic       nyq, bpsk;
    int         error_cnt = 0;
    int         check_count = 0;
    dmi_if bus ();
    dmi_dev dmi_dev_inst (.i_clk_sys(i_clk_sys), .i_nrst(i_nrst), .bus(bus), .i_i_sample(smp_i),
        .i_q_sample(smp_q), .i_flt_i(flt_i), .i_flt_q(flt_q), .o_flt_in_i(fin_i), .o_flt_in_q(fin_q),
        .o_rec_i(rec_i), .o_rec_q(rec_q), .o_nyq_en(nyq), .o_bpsk(bpsk), .o_cfg(cfg));
    dmi_host #(.QTR_CYC(8)) dmi_host_inst (.i_clk_sys(i_clk_sys), .i_nrst(i_nrst), .bus(bus),
        .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata));
    dmi_assertions dmi_assertions_inst (.i_clk_sys(i_clk_sys), .i_nrst(i_nrst), .i_scl(bus.scl),
        .i_sda(bus.sda), .i_sda_host_oe(bus.sda_host_oe), .i_sda_dev_oe(bus.sda_dev_oe));

    initial
    begin
        i_clk_sys = 1'b0;
        forever #25 i_clk_sys = ~i_clk_sys;
    end

    task automatic results();
        $display("checks %0d mismatches %0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : results

    task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
        check_count++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask : chk

    task automatic wr(input logic [2:0] a, input logic [7:0] v);
        @(posedge i_clk_sys);
        i_addr  <= a;
        i_wdata <= v;
        i_wr    <= 1'b1;
        @(posedge i_clk_sys);
        i_wr    <= 1'b0;
    endtask : wr

    task automatic rd(input logic [2:0] a, output logic [7:0] v);
        @(posedge i_clk_sys);
        i_addr <= a;
        i_rd   <= 1'b1;
        @(posedge i_clk_sys);
        i_rd   <= 1'b0;
        #1 v = o_rdata;
    endtask : rd

    // One host job; go 01 writes, 02 reads into the read-data register
    task automatic job(input logic [7:0] idx, input logic [7:0] v, input logic [7:0] go);
        int n;
        wr(DMI_HREG_INDEX, idx);
        wr(DMI_HREG_WDATA, v);
        wr(DMI_HREG_CTRL, go);
        d = 8'h01;
        for (n = 0; n < 4000 && d[DMI_STAT_BUSY] !== 1'b0; n++)
            rd(DMI_HREG_STATUS, d);
        if (d[DMI_STAT_BUSY] !== 1'b0)
        begin
            error_cnt++;
            $display("[FAIL] %0t job hung", $time);
            results();
        end
        chk({7'h00, d[DMI_STAT_NACK]}, 8'h00, "ack");
        if (go == 8'h02)
            rd(DMI_HREG_RDATA, d);
    endtask : job

    task automatic rst();
        i_nrst <= 1'b0;
        repeat (4) @(posedge i_clk_sys);
        i_nrst <= 1'b1;
        repeat (3) @(posedge i_clk_sys);
    endtask : rst

    task automatic t_cfg();
        logic [7:0] vals [4] = '{8'h01, 8'h02, 8'h08, 8'h0b};
        chk(cfg, 8'h04, "reset cfg");
        foreach (vals[k])
        begin
            job(DMI_IDX_CFG, vals[k], 8'h01);
            chk(cfg, vals[k], "cfg write");
            chk({6'h00, bpsk, nyq}, {6'h00, vals[k][3], vals[k][2]}, "mode");
            job(DMI_IDX_CFG, 8'h00, 8'h02);
            chk(d, vals[k], "cfg read");
        end
        $display("cfg test done");
    endtask : t_cfg

    task automatic t_id();
        // Only defined indices, unused bits zero
        job(DMI_IDX_ID, 8'h00, 8'h01);
        chk(cfg, 8'h0b, "cfg kept");
        job(DMI_IDX_CFG, 8'h00, 8'h02);
        chk(d, 8'h0b, "cfg read kept");
        job(DMI_IDX_ID, 8'h00, 8'h02);
        chk(d, DMI_RELEASE_ID, "release id");
        $display("id test done");
    endtask : t_id

    // Unsigned samples are re-centred by flipping the top bit
    task automatic t_path();
        logic [7:0] vals [5] = '{8'h00, 8'h06, 8'h02, 8'h01, 8'h03};
        foreach (vals[k])
        begin
            job(DMI_IDX_CFG, vals[k], 8'h01);
            ei = vals[k][1] ? {smp_i[5], smp_i} : {~smp_i[5], ~smp_i[5], smp_i[4:0]};
            eq = vals[k][1] ? {smp_q[5], smp_q} : {~smp_q[5], ~smp_q[5], smp_q[4:0]};
            eq = vals[k][0] ? 7'h00 - eq : eq;
            repeat (4) @(posedge i_clk_sys);
            chk({1'b0, fin_i}, {1'b0, ei}, "i in");
            chk({1'b0, fin_q}, {1'b0, eq}, "q in");
            chk({1'b0, rec_i}, {1'b0, vals[k][2] ? flt_i : ei}, "rec i");
            chk({1'b0, rec_q}, {1'b0, vals[k][2] ? flt_q : eq}, "rec q");
        end
        $display("path test done");
    endtask : t_path

    task automatic t_mid();
        wr(DMI_HREG_INDEX, DMI_IDX_CFG);
        wr(DMI_HREG_WDATA, 8'h08);
        wr(DMI_HREG_CTRL, 8'h01);
        repeat (100) @(posedge i_clk_sys);
        rst();
        chk(cfg, 8'h04, "cfg after reset");
        chk({7'h00, bus.sda}, 8'h01, "line released");
        job(8'h0b, 8'h00, 8'h01);
        job(DMI_IDX_CFG, 8'h00, 8'h02);
        chk(d, 8'h04, "pointer after stop");
        $display("reset test done");
    endtask : t_mid

    initial
    begin
        i_nrst  = 1'b0;
        i_wr    = 1'b0;
        i_rd    = 1'b0;
        i_addr  = 3'h0;
        i_wdata = 8'h00;
        smp_i   = 6'h05;
        smp_q   = 6'h2a;
        flt_i   = 7'h11;
        flt_q   = 7'h6c;
        rst();
        t_cfg();
        t_id();
        t_path();
        t_mid();
        results();
    end
endmodule : tb
`default_nettype wire
